// >>> verification/board_straps.sv
`timescale 1ns/1ps
module board_straps (
	input wire logic ref_clk,
	input wire logic strap_level,
	input wire logic [2:0] sel_code,
	input wire logic slot_swap,
	output logic [2:0] speed_select_input,
	output logic slot_occupied_n,
	output logic serial_request_strap_n
);
	logic [3:0] swap_q = 4'h0;
	// Slot reads occupied (low) for fifteen cycles, then empty again
	always @(posedge ref_clk) begin
		swap_q <= slot_swap ? 4'hF : swap_q - {3'h0, swap_q != 4'h0};
	end
	assign slot_occupied_n = swap_q == 4'h0;
	assign speed_select_input = sel_code;
	assign serial_request_strap_n = strap_level;
endmodule // board_straps

// >>> verification/bus_select_assertions.sv
`timescale 1ns/1ps
module bus_select_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [select_regs_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [select_regs_pkg::SEL_W-1:0] speed_select_output,
	input wire logic watchdog_reset_out_n,
	input wire logic watchdog_timeout,
	input wire logic select_port_enable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic acc;
	assign acc = psel && penable;
	chk_ready_tied: assert property (pready) else $error("pready low");
	chk_err_access: assert property (pslverr |-> acc) else $error("pslverr outside access");
	chk_unmapped_err: assert property (acc && paddr == 20'h000C4 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (acc && paddr == 20'h003C0 |-> !pslverr) else $error("config refused");
	chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	chk_enable_write: assert property (acc && pwrite && pstrb[0] && paddr == 20'h000C0
		|=> select_port_enable == $past(pwdata[0])) else $error("port enable not written");
	chk_enable_hold: assert property ($changed(select_port_enable) |-> $past(pwrite) && $past(penable))
		else $error("port enable moved without write");
	chk_wdrst_cause: assert property ($fell(watchdog_reset_out_n) |-> $past(watchdog_timeout))
		else $error("watchdog reset without timeout");
	chk_wdrst_width: assert property (!watchdog_reset_out_n |=> watchdog_reset_out_n) else $error("wd reset too long");
	chk_reset_vals: assert property ($past(srst) |-> speed_select_output == 3'h2 && watchdog_reset_out_n)
		else $error("bad values after reset");
endmodule // bus_select_checker

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, err, watchdog_timeout, slot_swap, strap;
	logic watchdog_reset_out_n, select_port_enable, slot_occupied_n, serial_request_strap_n;
	logic [select_regs_pkg::PADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [2:0] sel_code, speed_select_input, speed_select_output;
	logic [7:0] key [4] = '{8'h32, 8'h5D, 8'h42, 8'hAC};
	int n_errors, checks, lows;
	localparam logic [15:0] BASE = 16'h0AF8;
	bus_select_override DUT (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .speed_select_input, .slot_occupied_n, .serial_request_strap_n, .watchdog_timeout,
		.speed_select_output, .watchdog_reset_out_n, .select_port_enable);
	board_straps straps (.ref_clk, .strap_level(strap), .sel_code, .slot_swap, .speed_select_input,
		.slot_occupied_n, .serial_request_strap_n);
	function automatic logic [19:0] cfg(input logic [7:0] idx);
		return {10'h0, idx, 2'h0};
	endfunction
	function automatic logic [19:0] io(input logic [2:0] ofs);
		return {2'h2, BASE + {13'h0, ofs}, 2'h0};
	endfunction
	task automatic xfer(input logic w, input logic [19:0] a, input logic [7:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 4'hF);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rdchk(input string what, input logic [19:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00, 4'h0);
		chk(what, {24'h0, exp}, rd);
	endtask
	// Counts low cycles of the reset pin after one timeout pulse
	task automatic wdog();
		watchdog_timeout <= 1'b1;
		@(posedge ref_clk);
		watchdog_timeout <= 1'b0;
		lows = 0;
		repeat (4) begin
			@(posedge ref_clk);
			lows += watchdog_reset_out_n === 1'b0;
		end
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#20000;
		n_errors++;
		end_of_test();
	end
	initial begin
		{srst, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 59'h0};
		{watchdog_timeout, slot_swap, sel_code} = 5'h1;
		strap = 1'b1;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("output reset", 32'h2, {29'h0, speed_select_output});
		rdchk("port enable", cfg(8'h30), 8'h00);
		rdchk("base upper", cfg(8'h60), 8'h00);
		rdchk("base lower", cfg(8'h61), 8'h00);
		rdchk("config", cfg(8'hF0), 8'h81);
		rdchk("manual", cfg(8'hF2), 8'h82);
		rdchk("key data", cfg(8'hF3), 8'hF3);
		xfer(1'b1, cfg(8'h30), 8'hFF, 4'hE);
		rdchk("strobe off", cfg(8'h30), 8'h00);
		wr(cfg(8'h30), 8'hFF);
		rdchk("enable set", cfg(8'h30), 8'h01);
		chk("enable pin", 32'h1, {31'h0, select_port_enable});
		wr(cfg(8'h60), BASE[15:8]);
		wr(cfg(8'h61), BASE[7:0]);
		rdchk("base upper set", cfg(8'h60), 8'h0A);
		rdchk("base lower set", cfg(8'h61), 8'hF8);
		rdchk("config io", io(3'h0), 8'h81);
		rdchk("manual io", io(3'h2), 8'h82);
		rdchk("unmapped", cfg(8'h31), 8'h00);
		chk("unmapped err", 32'h1, {31'h0, err});
		wr(cfg(8'h30), 8'h00);
		rdchk("io off", io(3'h0), 8'h00);
		chk("io off err", 32'h1, {31'h0, err});
		wr(cfg(8'h30), 8'h01);
		wr(io(3'h2), 8'h3D);
		rdchk("manual bypass", cfg(8'hF2), 8'h05);
		sel_code <= 3'h6;
		repeat (8) @(posedge ref_clk);
		chk("bypass out", 32'h6, {29'h0, speed_select_output});
		rdchk("input status", io(3'h4), 8'h06);
		wr(cfg(8'hF2), 8'h85);
		repeat (2) @(posedge ref_clk);
		chk("manual out", 32'h5, {29'h0, speed_select_output});
		wr(cfg(8'hF2), 8'h05);
		slot_swap <= 1'b1;
		@(posedge ref_clk);
		slot_swap <= 1'b0;
		repeat (12) @(posedge ref_clk);
		rdchk("slot restore", cfg(8'hF2), 8'h85);
		wr(cfg(8'hF2), 8'h05);
		wdog();
		chk("wd pulse", 32'h1, lows);
		rdchk("wd restore", cfg(8'hF2), 8'h85);
		wr(cfg(8'hF0), 8'h7E);
		rdchk("config cleared", cfg(8'hF0), 8'h00);
		wr(cfg(8'hF2), 8'h05);
		wdog();
		chk("wd quiet", 32'h0, lows);
		chk("wd idle", 32'h1, {31'h0, watchdog_reset_out_n});
		rdchk("wd blocked", cfg(8'hF2), 8'h05);
		foreach (key[i]) begin
			wr(cfg(8'hF3), key[i]);
		end
		rdchk("key ok", cfg(8'hF2), 8'h45);
		wr(cfg(8'hF2), 8'h05);
		rdchk("key read only", cfg(8'hF2), 8'h45);
		wr(cfg(8'hF3), 8'h35);
		rdchk("key relock", io(3'h2), 8'h05);
		rdchk("key data io", io(3'h3), 8'h35);
		// Second reset with the strap pulled low
		strap <= 1'b0;
		srst <= 1'b1;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rdchk("strap low config", cfg(8'hF0), 8'h01);
		rdchk("manual again", cfg(8'hF2), 8'h82);
		rdchk("enable again", cfg(8'h30), 8'h00);
		rdchk("base upper again", cfg(8'h60), 8'h00);
		rdchk("base lower again", cfg(8'h61), 8'h00);
		wdog();
		chk("wd strap off", 32'h0, lows);
		end_of_test();
	end
endmodule // tb
bind bus_select_override bus_select_checker chk_i (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .speed_select_output, .watchdog_reset_out_n, .watchdog_timeout,
	.select_port_enable);

// >>> verilog/bus_select_override.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Operation
// - Port enable bit 0 at index 30h switches the I/O window off or on.
// - Index 60h holds base address upper byte, reset zero.
// - Index 61h holds base address lower byte, reset zero.
// - Runtime registers answer at index and at base plus offset; F0h at 00h.
// - Watchdog reset-output enable resets from strap level sampled after reset.
// - Timeout with that enable set drives watchdog reset low; otherwise stays high.
// - Watchdog clear enable, reset 1, lets timeout restore manual mode; clear blocks it.
// - Manual mode returns to 1 on slot fall, or timeout with clear enable.
// - Manual mode clear copies input to output; set drives manual value.
// - Manual value bits 2-0 drive output in manual mode, reset 2h.
// - Key-accepted bit 6 of manual register is read-only, 1 after unlock.
// - Bytes 32h,5Dh,42h,ACh to key register unlock; 35h while unlocked relocks.
module bus_select_override (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [select_regs_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [select_regs_pkg::SEL_W-1:0] speed_select_input,
	input wire logic slot_occupied_n,
	input wire logic serial_request_strap_n,
	input wire logic watchdog_timeout,
	output logic [select_regs_pkg::SEL_W-1:0] speed_select_output,
	output logic watchdog_reset_out_n,
	output logic select_port_enable
);
	// Register state
	logic port_enable_q;
	logic [7:0] base_upper_q;
	logic [7:0] base_lower_q;
	logic watchdog_reset_output_enable_q;
	logic watchdog_reset_output_enable_d;
	logic wd_clear_en_q;
	logic manual_mode_q;
	logic manual_mode_d;
	logic [select_regs_pkg::SEL_W-1:0] manual_value_q;
	logic [7:0] key_data_q;
	logic key_ok_q;
	logic key_ok_d;
	select_regs_pkg::key_state_t key_state_q;
	select_regs_pkg::key_state_t key_state_d;
	logic [1:0] strap_wait_q;
	logic [1:0] strap_wait_d;
	logic [31:0] prdata_q;
	logic prdata_err_q;
	logic [select_regs_pkg::SEL_W-1:0] sel_out_q;
	logic wd_reset_n_q;

	// Synchronised pins
	logic [select_regs_pkg::SEL_W-1:0] sel_in_level;
	logic slot_level;
	logic slot_fall;
	logic strap_level;

	pin_sync #(
		.WIDTH(select_regs_pkg::SEL_W),
		.RESET_VAL('0)
	) u_sel_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.pin_async(speed_select_input),
		.level(sel_in_level),
		.fall()
	);

	pin_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) u_slot_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.pin_async(slot_occupied_n),
		.level(slot_level),
		.fall(slot_fall)
	);

	pin_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) u_strap_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.pin_async(serial_request_strap_n),
		.level(strap_level),
		.fall()
	);

	// Address decode: config space by index, I/O space by base plus offset
	wire io_space = paddr[select_regs_pkg::IO_SPACE_BIT];
	wire [7:0] cfg_index = paddr[select_regs_pkg::IDX_MSB:select_regs_pkg::IDX_LSB];
	wire cfg_pad_zero = (paddr[select_regs_pkg::CFG_PAD_MSB:select_regs_pkg::CFG_PAD_LSB] == '0);
	wire [15:0] io_addr = paddr[select_regs_pkg::IO_ADDR_MSB:select_regs_pkg::IO_ADDR_LSB];
	wire [15:0] base_addr = {base_upper_q, base_lower_q};
	wire io_base_hit = port_enable_q
		& (io_addr[15:select_regs_pkg::RUNTIME_OFS_BITS] == base_addr[15:select_regs_pkg::RUNTIME_OFS_BITS]);
	wire [2:0] io_offset = io_addr[select_regs_pkg::RUNTIME_OFS_BITS-1:0];
	wire cfg_hit = ~io_space & cfg_pad_zero;
	wire io_hit = io_space & io_base_hit;

	wire sel_port_enable = cfg_hit & (cfg_index == select_regs_pkg::IDX_PORT_ENABLE);
	wire sel_base_upper = cfg_hit & (cfg_index == select_regs_pkg::IDX_BASE_UPPER);
	wire sel_base_lower = cfg_hit & (cfg_index == select_regs_pkg::IDX_BASE_LOWER);
	wire sel_config = (cfg_hit & (cfg_index == select_regs_pkg::IDX_CONFIG))
		| (io_hit & (io_offset == select_regs_pkg::OFS_CONFIG));
	wire sel_manual = (cfg_hit & (cfg_index == select_regs_pkg::IDX_MANUAL))
		| (io_hit & (io_offset == select_regs_pkg::OFS_MANUAL));
	wire sel_key = (cfg_hit & (cfg_index == select_regs_pkg::IDX_KEY))
		| (io_hit & (io_offset == select_regs_pkg::OFS_KEY));
	wire sel_input_status = (cfg_hit & (cfg_index == select_regs_pkg::IDX_INPUT_STATUS))
		| (io_hit & (io_offset == select_regs_pkg::OFS_INPUT_STATUS));
	wire mapped = sel_port_enable | sel_base_upper | sel_base_lower | sel_config
		| sel_manual | sel_key | sel_input_status;

	// APB phases; slave never waits so every access phase completes
	wire setup_phase = psel & ~penable;
	wire access_phase = psel & penable;
	wire byte_write = access_phase & pwrite & pstrb[0] & mapped;
	wire [7:0] wbyte = pwdata[7:0];

	wire wr_port_enable = byte_write & sel_port_enable;
	wire wr_base_upper = byte_write & sel_base_upper;
	wire wr_base_lower = byte_write & sel_base_lower;
	wire wr_config = byte_write & sel_config;
	wire wr_manual = byte_write & sel_manual;
	wire wr_key = byte_write & sel_key;

	// Read values, reserved bits zero
	wire [7:0] rd_port_enable = {7'h00, port_enable_q};
	wire [7:0] rd_config = {watchdog_reset_output_enable_q, 6'h00, wd_clear_en_q};
	wire [7:0] rd_manual = {manual_mode_q, key_ok_q, 3'h0, manual_value_q};
	wire [7:0] rd_input_status = {5'h00, sel_in_level};
	wire [7:0] rd_byte = ({8{sel_port_enable}} & rd_port_enable)
		| ({8{sel_base_upper}} & base_upper_q)
		| ({8{sel_base_lower}} & base_lower_q)
		| ({8{sel_config}} & rd_config)
		| ({8{sel_manual}} & rd_manual)
		| ({8{sel_key}} & key_data_q)
		| ({8{sel_input_status}} & rd_input_status);

	// Watchdog and slot restore of the marked bit
	wire wd_restore = watchdog_timeout & wd_clear_en_q;
	wire restore_manual = slot_fall | wd_restore;
	wire strap_take = (strap_wait_q == 2'h1);

	always_comb begin
		manual_mode_d = manual_mode_q;
		if (restore_manual) begin
			manual_mode_d = select_regs_pkg::RST_MANUAL_MODE;
		end else if (wr_manual) begin
			manual_mode_d = wbyte[select_regs_pkg::MANUAL_MODE_BIT];
		end
	end

	always_comb begin
		watchdog_reset_output_enable_d = watchdog_reset_output_enable_q;
		strap_wait_d = strap_wait_q;
		if (strap_wait_q != 2'h0) begin
			strap_wait_d = strap_wait_q - 2'h1;
		end
		if (strap_take) begin
			watchdog_reset_output_enable_d = strap_level;
		end else if (wr_config) begin
			watchdog_reset_output_enable_d = wbyte[select_regs_pkg::WATCHDOG_RESET_OUTPUT_ENABLE_BIT];
		end
	end

	// Unlock key sequence tracker
	wire key_first = (wbyte == select_regs_pkg::KEY_BYTE0);
	always_comb begin
		key_state_d = key_state_q;
		key_ok_d = key_ok_q;
		if (wr_key) begin
			if (key_ok_q && wbyte == select_regs_pkg::KEY_RELOCK) begin
				key_ok_d = 1'b0;
				key_state_d = select_regs_pkg::KEY_IDLE;
			end else begin
				case (key_state_q)
					select_regs_pkg::KEY_IDLE: begin
						key_state_d = key_first ? select_regs_pkg::KEY_GOT0 : select_regs_pkg::KEY_IDLE;
					end
					select_regs_pkg::KEY_GOT0: begin
						if (wbyte == select_regs_pkg::KEY_BYTE1) begin
							key_state_d = select_regs_pkg::KEY_GOT1;
						end else begin
							key_state_d = key_first ? select_regs_pkg::KEY_GOT0 : select_regs_pkg::KEY_IDLE;
						end
					end
					select_regs_pkg::KEY_GOT1: begin
						if (wbyte == select_regs_pkg::KEY_BYTE2) begin
							key_state_d = select_regs_pkg::KEY_GOT2;
						end else begin
							key_state_d = key_first ? select_regs_pkg::KEY_GOT0 : select_regs_pkg::KEY_IDLE;
						end
					end
					select_regs_pkg::KEY_GOT2: begin
						if (wbyte == select_regs_pkg::KEY_BYTE3) begin
							key_ok_d = 1'b1;
							key_state_d = select_regs_pkg::KEY_IDLE;
						end else begin
							key_state_d = key_first ? select_regs_pkg::KEY_GOT0 : select_regs_pkg::KEY_IDLE;
						end
					end
					default: begin
						key_state_d = select_regs_pkg::KEY_IDLE;
					end
				endcase
			end
		end
	end

	// Output selection: bypass input or manual value
	wire [select_regs_pkg::SEL_W-1:0] sel_out_d = manual_mode_q ? manual_value_q : sel_in_level;
	wire wd_fire = watchdog_timeout & watchdog_reset_output_enable_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			port_enable_q <= select_regs_pkg::RST_PORT_ENABLE;
		end else if (wr_port_enable) begin
			port_enable_q <= wbyte[select_regs_pkg::PORT_ENABLE_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			base_upper_q <= select_regs_pkg::RST_BASE_UPPER;
			base_lower_q <= select_regs_pkg::RST_BASE_LOWER;
		end else begin
			if (wr_base_upper) begin
				base_upper_q <= wbyte;
			end
			if (wr_base_lower) begin
				base_lower_q <= wbyte;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			watchdog_reset_output_enable_q <= 1'b0;
			strap_wait_q <= select_regs_pkg::STRAP_SETTLE;
			wd_clear_en_q <= select_regs_pkg::RST_WD_CLEAR_EN;
		end else begin
			watchdog_reset_output_enable_q <= watchdog_reset_output_enable_d;
			strap_wait_q <= strap_wait_d;
			if (wr_config) begin
				wd_clear_en_q <= wbyte[select_regs_pkg::WD_CLEAR_EN_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			manual_mode_q <= select_regs_pkg::RST_MANUAL_MODE;
			manual_value_q <= select_regs_pkg::RST_MANUAL_VALUE;
		end else begin
			manual_mode_q <= manual_mode_d;
			if (wr_manual) begin
				manual_value_q <= wbyte[select_regs_pkg::SEL_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			key_data_q <= select_regs_pkg::RST_KEY_DATA;
			key_ok_q <= 1'b0;
			key_state_q <= select_regs_pkg::KEY_IDLE;
		end else begin
			key_ok_q <= key_ok_d;
			key_state_q <= key_state_d;
			if (wr_key) begin
				key_data_q <= wbyte;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sel_out_q <= select_regs_pkg::RST_MANUAL_VALUE;
			wd_reset_n_q <= 1'b1;
		end else begin
			sel_out_q <= sel_out_d;
			wd_reset_n_q <= ~wd_fire;
		end
	end

	// Read data captured in the setup cycle, presented in the access cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prdata_q <= 32'h0000_0000;
			prdata_err_q <= 1'b0;
		end else if (setup_phase) begin
			prdata_q <= {24'h00_0000, rd_byte};
			prdata_err_q <= ~mapped;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = access_phase & prdata_err_q;
	assign speed_select_output = sel_out_q;
	assign watchdog_reset_out_n = wd_reset_n_q;
	assign select_port_enable = port_enable_q;
endmodule // bus_select_override

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync2_q;
	logic [WIDTH-1:0] sync3_q;
	logic [WIDTH-1:0] level_q;
	logic [WIDTH-1:0] fall_q;
	wire [WIDTH-1:0] agree = ~(sync2_q ^ sync3_q);
	wire [WIDTH-1:0] level_d = (agree & sync3_q) | (~agree & level_q);

	// Sampling chain free-runs so the pin is settled at reset release
	always_ff @(posedge ref_clk) begin
		meta_q <= pin_async;
		sync2_q <= meta_q;
		sync3_q <= sync2_q;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			level_q <= RESET_VAL;
			fall_q <= '0;
		end else begin
			level_q <= level_d;
			fall_q <= level_q & ~level_d;
		end
	end

	assign level = level_q;
	assign fall = fall_q;
endmodule // pin_sync

// >>> verilog/select_regs_pkg.sv
package select_regs_pkg;
	// Register indices; byte address on APB is four times the index
	localparam logic [7:0] IDX_PORT_ENABLE = 8'h30;
	localparam logic [7:0] IDX_BASE_UPPER = 8'h60;
	localparam logic [7:0] IDX_BASE_LOWER = 8'h61;
	localparam logic [7:0] IDX_CONFIG = 8'hF0;
	localparam logic [7:0] IDX_MANUAL = 8'hF2;
	localparam logic [7:0] IDX_KEY = 8'hF3;
	localparam logic [7:0] IDX_INPUT_STATUS = 8'hF4;

	// Offsets of the runtime registers from the I/O base address
	localparam logic [2:0] OFS_CONFIG = 3'h0;
	localparam logic [2:0] OFS_MANUAL = 3'h2;
	localparam logic [2:0] OFS_KEY = 3'h3;
	localparam logic [2:0] OFS_INPUT_STATUS = 3'h4;
	localparam logic [4:0] RUNTIME_INDEX_TOP = 5'h1E;
	localparam int RUNTIME_OFS_BITS = 3;

	// APB address layout
	localparam int PADDR_W = 20;
	localparam int IO_SPACE_BIT = 19;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;
	localparam int IO_ADDR_LSB = 2;
	localparam int IO_ADDR_MSB = 17;
	localparam int CFG_PAD_LSB = 10;
	localparam int CFG_PAD_MSB = 18;

	// Field positions
	localparam int PORT_ENABLE_BIT = 0;
	localparam int WATCHDOG_RESET_OUTPUT_ENABLE_BIT = 7;
	localparam int WD_CLEAR_EN_BIT = 0;
	localparam int MANUAL_MODE_BIT = 7;
	localparam int KEY_OK_BIT = 6;
	localparam int SEL_W = 3;

	// Reset values
	localparam logic RST_PORT_ENABLE = 1'b0;
	localparam logic [7:0] RST_BASE_UPPER = 8'h00;
	localparam logic [7:0] RST_BASE_LOWER = 8'h00;
	localparam logic RST_WD_CLEAR_EN = 1'b1;
	localparam logic RST_MANUAL_MODE = 1'b1;
	localparam logic [2:0] RST_MANUAL_VALUE = 3'h2;
	localparam logic [7:0] RST_KEY_DATA = 8'hF3;

	// Unlock key sequence and relock byte
	localparam logic [7:0] KEY_BYTE0 = 8'h32;
	localparam logic [7:0] KEY_BYTE1 = 8'h5D;
	localparam logic [7:0] KEY_BYTE2 = 8'h42;
	localparam logic [7:0] KEY_BYTE3 = 8'hAC;
	localparam logic [7:0] KEY_RELOCK = 8'h35;

	// Cycles after reset release before the strap level is taken
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT0,
		KEY_GOT1,
		KEY_GOT2
	} key_state_t;
endpackage
